// ===== verilog/pam_pkg.sv
// shared constants and types of the protection and event monitor
package pam_pkg;
   // measurement sample as delivered by the front end
   typedef struct packed {
      logic        valid;   // one-cycle strobe: new sample
      logic [15:0] volt;    // input voltage
      logic [15:0] curr;    // input current
      logic [15:0] power;   // input power
   } pam_meas_t;

   // register byte offsets
   localparam logic [5:0] REG_CMD    = 6'h00;
   localparam logic [5:0] REG_STAT   = 6'h04;
   localparam logic [5:0] REG_CFG    = 6'h08;
   localparam logic [5:0] REG_OVPTHR = 6'h0c;
   localparam logic [5:0] REG_OCPTHR = 6'h10;
   localparam logic [5:0] REG_OPPTHR = 6'h14;
   localparam logic [5:0] REG_EVTHR0 = 6'h18;
   localparam logic [5:0] REG_EVACT  = 6'h2c;
   localparam logic [5:0] REG_PROF   = 6'h30;

   // command register bit positions (write one to act)
   localparam int CMD_ON     = 0;
   localparam int CMD_OFF    = 1;
   localparam int CMD_ACK    = 2;
   localparam int CMD_REINIT = 3;

   // alarm flag positions
   localparam int AL_OVP = 0;
   localparam int AL_OCP = 1;
   localparam int AL_OPP = 2;
   localparam int AL_PF  = 3;
   localparam int AL_OT  = 4;
   localparam int AL_FL  = 5;
   localparam int AL_EV  = 6;
   localparam int N_AL   = 7;

   // user event positions
   localparam int EV_UV = 0;
   localparam int EV_OV = 1;
   localparam int EV_UC = 2;
   localparam int EV_OC = 3;
   localparam int EV_OP = 4;
   localparam int N_EV  = 5;

   // event action codes
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_SIG  = 2'h1;
   localparam logic [1:0] ACT_WARN = 2'h2;
   localparam logic [1:0] ACT_ALRM = 2'h3;

   // default alarm threshold as ratio 11/10 of nominal
   localparam int DEF_NUM = 11;
   localparam int DEF_DEN = 10;
endpackage

// ===== verilog/pam_monitor.sv
// protection alarm and user event monitor with avalon-mm registers
`timescale 1ns/10ps
module pam_monitor #(
   parameter logic [15:0] U_NOM  = 16'h2710, // nominal voltage
   parameter logic [15:0] I_NOM  = 16'h1388, // nominal current
   parameter logic [15:0] P_NOM  = 16'hc350, // nominal power
   parameter int          N_PROF = 4         // stored user profiles
) (
   // clock and reset
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   // avalon-mm slave
   input  wire logic [5:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   // measurement path and hardware alarms
   input  wire pam_pkg::pam_meas_t meas_i,
   input  wire logic              supply_fail_i,
   input  wire logic              overtemp_i,
   input  wire logic              follower_lost_i,
   // input switch and indications
   output logic                   dc_input_on_o,
   output logic                   alarm_ind_o,
   output logic                   warning_ind_o,
   output logic                   event_ind_o,
   output logic                   sound_o,
   output logic                   analog_alarm_o
);
   localparam int PW = (N_PROF > 1) ? $clog2(N_PROF) : 1;
   localparam logic [15:0] ZERO16 = 16'h0000;

   // 110 percent defaults, kept wide against overflow
   localparam logic [19:0] U_MAX =
      20'((32'(U_NOM) * pam_pkg::DEF_NUM) / pam_pkg::DEF_DEN);
   localparam logic [19:0] I_MAX =
      20'((32'(I_NOM) * pam_pkg::DEF_NUM) / pam_pkg::DEF_DEN);
   localparam logic [19:0] P_MAX =
      20'((32'(P_NOM) * pam_pkg::DEF_NUM) / pam_pkg::DEF_DEN);

   // register state
   logic [19:0]   ovp_thr_r;                   // overvoltage limit
   logic [19:0]   ocp_thr_r;                   // overcurrent limit
   logic [19:0]   opp_thr_r;                   // overpower limit
   logic [15:0]   ev_thr_r [N_PROF][pam_pkg::N_EV]; // event limits
   logic [1:0]    ev_act_r [N_PROF][pam_pkg::N_EV]; // event actions
   logic [PW-1:0] prof_r;                      // active profile
   logic          sound_en_r;                  // shared sound enable
   logic          input_on_r;                  // dc input state
   logic [pam_pkg::N_AL-1:0] alarm_r;          // latched alarms
   logic [pam_pkg::N_AL-1:0] cond_r;           // condition present
   logic [pam_pkg::N_EV-1:0] ev_fired_r;       // latched events
   logic          wait_r;                      // waitrequest flop
   logic [31:0]   rdata_r;                     // read data flop
   logic          alarm_ind_r;
   logic          warn_ind_r;
   logic          ev_ind_r;
   logic          sound_r;
   logic          analog_r;

   // bus decode and compare helpers
   logic          wr_go;                       // write takes effect
   logic [pam_pkg::N_EV-1:0] ev_hit;           // event raw compare
   logic [pam_pkg::N_AL-1:0] cond_now;         // alarm raw compare
   logic          cmd_on;
   logic          cmd_off;
   logic          cmd_ack;
   logic          cmd_reinit;
   logic          cfg_ok;                      // settings writable
   logic          ev_alarm_set;                // alarm-action fired
   logic          any_alarm_nxt;

   // clamp a written value to a top limit
   function automatic logic [19:0] clamp(input logic [31:0] v,
                                         input logic [19:0] top);
      clamp = (v > 32'(top)) ? top : v[19:0];
   endfunction

   // event limit register offset check
   function automatic logic is_ev_thr(input logic [5:0] a,
                                      input int i);
      is_ev_thr = (a == 6'(pam_pkg::REG_EVTHR0 + 4 * i));
   endfunction

   assign wr_go      = avs_write_i && !wait_r;
   assign cmd_on     = wr_go && avs_address_i == pam_pkg::REG_CMD
                       && avs_writedata_i[pam_pkg::CMD_ON];
   assign cmd_off    = wr_go && avs_address_i == pam_pkg::REG_CMD
                       && avs_writedata_i[pam_pkg::CMD_OFF];
   assign cmd_ack    = wr_go && avs_address_i == pam_pkg::REG_CMD
                       && avs_writedata_i[pam_pkg::CMD_ACK];
   assign cmd_reinit = wr_go && avs_address_i == pam_pkg::REG_CMD
                       && avs_writedata_i[pam_pkg::CMD_REINIT];
   assign cfg_ok     = wr_go && !input_on_r;

   // raw alarm comparisons on the present sample
   always_comb begin
      cond_now = cond_r;
      if (meas_i.valid) begin
         // reaching the limit counts
         cond_now[pam_pkg::AL_OVP] = 20'(meas_i.volt) >= ovp_thr_r;
         cond_now[pam_pkg::AL_OCP] = 20'(meas_i.curr) >= ocp_thr_r;
         cond_now[pam_pkg::AL_OPP] = 20'(meas_i.power) >= opp_thr_r;
      end
      cond_now[pam_pkg::AL_PF] = supply_fail_i;
      cond_now[pam_pkg::AL_OT] = overtemp_i;
      cond_now[pam_pkg::AL_FL] = follower_lost_i;
      cond_now[pam_pkg::AL_EV] = 1'b0;
   end

   // user event comparisons, gated by input state and action
   genvar g;
   generate
      for (g = 0; g < pam_pkg::N_EV; g++) begin : g_ev
         logic [15:0] m;   // measured quantity for this event
         logic        under; // event fires below its limit
         assign m = (g < 2) ? meas_i.volt :
                    (g < 4) ? meas_i.curr : meas_i.power;
         assign under = (g == pam_pkg::EV_UV) || (g == pam_pkg::EV_UC);
         assign ev_hit[g] = meas_i.valid && input_on_r
            && ev_act_r[prof_r][g] != pam_pkg::ACT_NONE
            && (under ? (m < ev_thr_r[prof_r][g])
                      : (m > ev_thr_r[prof_r][g]));
      end
   endgenerate

   // any fired event whose action is alarm
   always_comb begin
      ev_alarm_set = 1'b0;
      for (int i = 0; i < pam_pkg::N_EV; i++) begin
         if (ev_hit[i] && ev_act_r[prof_r][i] == pam_pkg::ACT_ALRM) begin
            ev_alarm_set = 1'b1;
         end
      end
   end

   // bus handshake: one wait cycle, then answer
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wait_r <= 1'b1;
      end else if ((avs_read_i || avs_write_i) && wait_r) begin
         wait_r <= 1'b0;
      end else begin
         wait_r <= 1'b1;
      end
   end

   // read data captured while the master waits
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read_i && wait_r) begin
         if (avs_address_i == pam_pkg::REG_STAT) begin
            rdata_r <= {12'h000, ev_fired_r, cond_r,
                        alarm_r, input_on_r};
         end else if (avs_address_i == pam_pkg::REG_CFG) begin
            rdata_r <= {31'h0000_0000, sound_en_r};
         end else if (avs_address_i == pam_pkg::REG_OVPTHR) begin
            rdata_r <= {12'h000, ovp_thr_r};
         end else if (avs_address_i == pam_pkg::REG_OCPTHR) begin
            rdata_r <= {12'h000, ocp_thr_r};
         end else if (avs_address_i == pam_pkg::REG_OPPTHR) begin
            rdata_r <= {12'h000, opp_thr_r};
         end else if (avs_address_i >= pam_pkg::REG_EVTHR0
                      && avs_address_i < pam_pkg::REG_EVACT
                      && avs_address_i[1:0] == 2'h0) begin
            rdata_r <= {16'h0000, ev_thr_r[prof_r][
               3'(((avs_address_i - pam_pkg::REG_EVTHR0) >> 2))]};
         end else if (avs_address_i == pam_pkg::REG_EVACT) begin
            rdata_r <= {22'h00_0000,
                        ev_act_r[prof_r][4], ev_act_r[prof_r][3],
                        ev_act_r[prof_r][2], ev_act_r[prof_r][1],
                        ev_act_r[prof_r][0]};
         end else if (avs_address_i == pam_pkg::REG_PROF) begin
            rdata_r <= 32'(prof_r);
         end else begin
            // unmapped and write-only offsets read zero
            rdata_r <= 32'h0000_0000;
         end
      end
   end

   // alarm thresholds and sound enable
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ovp_thr_r  <= U_MAX;
         ocp_thr_r  <= I_MAX;
         opp_thr_r  <= P_MAX;
         sound_en_r <= 1'b0;
      end else if (cfg_ok) begin
         // out-of-range values clamp to 1.1 times nominal
         if (avs_address_i == pam_pkg::REG_OVPTHR) begin
            ovp_thr_r <= clamp(avs_writedata_i, U_MAX);
         end else if (avs_address_i == pam_pkg::REG_OCPTHR) begin
            ocp_thr_r <= clamp(avs_writedata_i, I_MAX);
         end else if (avs_address_i == pam_pkg::REG_OPPTHR) begin
            opp_thr_r <= clamp(avs_writedata_i, P_MAX);
         end else if (avs_address_i == pam_pkg::REG_CFG) begin
            sound_en_r <= avs_writedata_i[0];
         end
      end
   end

   // event settings live in per-profile storage
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         prof_r <= '0;
         for (int p = 0; p < N_PROF; p++) begin
            for (int i = 0; i < pam_pkg::N_EV; i++) begin
               ev_thr_r[p][i] <= ZERO16;
               ev_act_r[p][i] <= pam_pkg::ACT_NONE;
            end
         end
      end else if (cfg_ok) begin
         if (avs_address_i == pam_pkg::REG_PROF) begin
            // profile switch loads its own settings
            prof_r <= PW'(avs_writedata_i);
         end else if (avs_address_i == pam_pkg::REG_EVACT) begin
            for (int i = 0; i < pam_pkg::N_EV; i++) begin
               ev_act_r[prof_r][i] <= avs_writedata_i[2*i +: 2];
            end
         end else begin
            for (int i = 0; i < pam_pkg::N_EV; i++) begin
               if (is_ev_thr(avs_address_i, i)) begin
                  // event limits top out at nominal
                  ev_thr_r[prof_r][i] <= 16'(clamp(avs_writedata_i,
                     (i < 2) ? 20'(U_NOM) :
                     (i < 4) ? 20'(I_NOM) : 20'(P_NOM)));
               end
            end
         end
      end
   end

   // last seen alarm conditions
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cond_r <= '0;
      end else begin
         cond_r <= cond_now;
      end
   end

   // latched alarms: set wins, ack clears only absent ones, follower loss only by reinit
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         alarm_r <= '0;
      end else begin
         for (int i = 0; i < pam_pkg::N_AL; i++) begin
            if (i == pam_pkg::AL_EV ? ev_alarm_set : cond_now[i]) begin
               alarm_r[i] <= 1'b1;
            end else if (i == pam_pkg::AL_FL) begin
               if (cmd_reinit) begin
                  alarm_r[i] <= 1'b0;
               end
            end else if (cmd_ack) begin
               alarm_r[i] <= 1'b0;
            end
         end
      end
   end

   // latched event status, cleared by ack
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ev_fired_r <= '0;
      end else begin
         ev_fired_r <= (cmd_ack ? '0 : ev_fired_r) | ev_hit;
      end
   end

   assign any_alarm_nxt = |alarm_r || |cond_now || ev_alarm_set;

   // dc input switch
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         input_on_r <= 1'b0;
      end else if (any_alarm_nxt || cmd_off) begin
         input_on_r <= 1'b0;
      end else if (cmd_on) begin
         input_on_r <= 1'b1;
      end
   end

   // indication outputs
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         alarm_ind_r <= 1'b0;
         warn_ind_r  <= 1'b0;
         ev_ind_r    <= 1'b0;
         sound_r     <= 1'b0;
         analog_r    <= 1'b0;
      end else begin
         alarm_ind_r <= |alarm_r;
         warn_ind_r  <= 1'b0;
         for (int i = 0; i < pam_pkg::N_EV; i++) begin
            if (ev_fired_r[i]
                && ev_act_r[prof_r][i] >= pam_pkg::ACT_WARN) begin
               warn_ind_r <= 1'b1;
            end
         end
         ev_ind_r    <= |ev_fired_r;
         sound_r     <= |alarm_r && sound_en_r;
         // only voltage, supply and temperature reach analog
         analog_r    <= alarm_r[pam_pkg::AL_OVP]
                        || alarm_r[pam_pkg::AL_PF]
                        || alarm_r[pam_pkg::AL_OT];
      end
   end

   assign avs_waitrequest_o = wait_r;
   assign avs_readdata_o    = rdata_r;
   assign dc_input_on_o     = input_on_r;
   assign alarm_ind_o       = alarm_ind_r;
   assign warning_ind_o     = warn_ind_r;
   assign event_ind_o       = ev_ind_r;
   assign sound_o           = sound_r;
   assign analog_alarm_o    = analog_r;

   // assertions guarding the protection behaviour
   a_alarm_forces_off: assert property (@(posedge mclk_i)
      disable iff (srst_i) |alarm_r |-> !input_on_r)
      else $error("input on while alarm latched");
   a_on_needs_ack: assert property (@(posedge mclk_i)
      disable iff (srst_i) $rose(input_on_r) |-> $past(cmd_on)
      && $past(alarm_r) == '0)
      else $error("input on without clean ack");
   a_ovp_latch: assert property (@(posedge mclk_i)
      disable iff (srst_i) meas_i.valid
      && 20'(meas_i.volt) >= ovp_thr_r
      |=> alarm_r[pam_pkg::AL_OVP] ##1 !input_on_r)
      else $error("overvoltage not latched");
   a_pf_latch: assert property (@(posedge mclk_i)
      disable iff (srst_i) supply_fail_i
      |=> alarm_r[pam_pkg::AL_PF] && !input_on_r)
      else $error("supply failure not latched");
   a_follower_hold: assert property (@(posedge mclk_i)
      disable iff (srst_i) alarm_r[pam_pkg::AL_FL] && !cmd_reinit
      |=> alarm_r[pam_pkg::AL_FL])
      else $error("follower alarm cleared without reinit");
   a_ev_off_quiet: assert property (@(posedge mclk_i)
      disable iff (srst_i) !input_on_r
      |=> (ev_fired_r & ~$past(ev_fired_r)) == '0)
      else $error("event latched while input off");
   a_ack_keeps_cond: assert property (@(posedge mclk_i)
      disable iff (srst_i) cmd_ack && cond_now[pam_pkg::AL_OT]
      |=> alarm_r[pam_pkg::AL_OT])
      else $error("ack cleared a present alarm");
   a_cfg_locked: assert property (@(posedge mclk_i)
      disable iff (srst_i) input_on_r |=> $stable(ovp_thr_r)
      && $stable(prof_r))
      else $error("setting changed while input on");
   a_sound_gate: assert property (@(posedge mclk_i)
      disable iff (srst_i) sound_o |-> $past(sound_en_r)
      && $past(|alarm_r))
      else $error("sound without enable or alarm");
endmodule

// ===== tb/pam_front.sv
// measurement front end and hardware alarm sources for the bench
`timescale 1ns/10ps
module pam_front (
   // clock
   input  wire logic          mclk_i,
   // sample bus and hardware alarm levels
   output pam_pkg::pam_meas_t meas_o,
   output logic               supply_fail_o,
   output logic               overtemp_o,
   output logic               follower_lost_o
);
   // quiet sample bus and healthy hardware at time zero
   initial begin
      meas_o = '0;
      {follower_lost_o, overtemp_o, supply_fail_o} = 3'h0;
   end
   // one sample: valid one cycle, data inverted afterwards so stale
   // values are never mistaken for a fresh sample
   task automatic sample(input logic [15:0] v, c, p);
      @(posedge mclk_i);
      meas_o <= '{1'b1, v, c, p};
      @(posedge mclk_i);
      meas_o <= '{1'b0, ~v, ~c, ~p};
   endtask
   // hardware levels {follower lost, overtemperature, supply fail}
   task automatic hw(input logic [2:0] f);
      @(posedge mclk_i);
      {follower_lost_o, overtemp_o, supply_fail_o} <= f;
   endtask
endmodule

// ===== tb/tb.sv
// self-checking bench of the protection and event monitor
`timescale 1ns/10ps
module tb;
   localparam logic [15:0] UN = 16'h2710; // nominal voltage
   localparam logic [15:0] IN = 16'h1388; // nominal current
   localparam logic [15:0] PN = 16'hc350; // nominal power
   logic               mclk_i;            // system clock
   logic               srst_i;            // synchronous reset
   logic [5:0]         avs_address_i;     // register bus request
   logic               avs_read_i;
   logic               avs_write_i;
   logic [31:0]        avs_writedata_i;
   logic [31:0]        avs_readdata_o;    // register bus answer
   logic               avs_waitrequest_o;
   pam_pkg::pam_meas_t meas;              // sample from front end
   logic [2:0]         hwl;               // follower, temperature, supply
   logic [5:0]         ind;               // on,alarm,warn,event,sound,analog
   logic [19:0]        thr [3];           // expected limits after reset
   logic [31:0]        q;                 // last read word
   int                 n_mismatch;
   int                 cmp_count;

   pam_monitor #(.U_NOM(UN), .I_NOM(IN), .P_NOM(PN), .N_PROF(4))
   i_pam_monitor (
      .mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .meas_i(meas),
      .supply_fail_i(hwl[0]), .overtemp_i(hwl[1]),
      .follower_lost_i(hwl[2]), .dc_input_on_o(ind[5]),
      .alarm_ind_o(ind[4]), .warning_ind_o(ind[3]), .event_ind_o(ind[2]),
      .sound_o(ind[1]), .analog_alarm_o(ind[0]));
   pam_front i_pam_front (
      .mclk_i(mclk_i), .meas_o(meas), .supply_fail_o(hwl[0]),
      .overtemp_o(hwl[1]), .follower_lost_o(hwl[2]));

   // 50 MHz clock
   always #10 mclk_i = ~mclk_i;

   // count one comparison, report a difference
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // compare the six indication outputs
   task automatic ichk(input logic [5:0] e);
      chk({26'h0, ind}, {26'h0, e});
   endtask
   // one transfer held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      // only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge mclk_i);
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // let latches and registered indications land
   task automatic settle;
      repeat (3) @(posedge mclk_i);
   endtask

   // reset values and an unmapped read
   task automatic t_reset;
      ichk(6'h00);
      rd(pam_pkg::REG_OVPTHR, {12'h0, thr[0]});
      rd(pam_pkg::REG_OCPTHR, {12'h0, thr[1]});
      rd(pam_pkg::REG_OPPTHR, {12'h0, thr[2]});
      rd(pam_pkg::REG_EVACT, 32'h0);
      rd(6'h3c, 32'h0);
      $display("test reset done");
   endtask
   // measured alarms hit exactly at their limits
   task automatic t_alarm;
      logic [15:0] s [3];
      wr(pam_pkg::REG_CFG, 32'h1);
      rd(pam_pkg::REG_CFG, 32'h1);
      wr(pam_pkg::REG_OVPTHR, 32'h000f_ffff);
      rd(pam_pkg::REG_OVPTHR, {12'h0, thr[0]});
      for (int i = 0; i < 3; i++) begin
         s = '{16'h0, 16'h0, 16'h0};
         s[i] = thr[i][15:0];
         wr(pam_pkg::REG_CMD, 32'h1);
         i_pam_front.sample(s[0], s[1], s[2]);
         settle;
         ichk({5'h09, i == 0});
         rd(pam_pkg::REG_STAT, (32'h2 << i) | (32'h100 << i));
         i_pam_front.sample(16'h0, 16'h0, 16'h0);
         wr(pam_pkg::REG_CMD, 32'h1);
         settle;
         ichk({5'h09, i == 0});
         rd(pam_pkg::REG_STAT, 32'h2 << i);
         wr(pam_pkg::REG_CMD, 32'h4);
         wr(pam_pkg::REG_CMD, 32'h1);
         settle;
         ichk(6'h20);
         wr(pam_pkg::REG_CMD, 32'h2);
      end
      $display("test alarm done");
   endtask
   // hardware alarms, ack while present, follower reinit
   task automatic t_hw;
      for (int i = 0; i < 3; i++) begin
         wr(pam_pkg::REG_CMD, 32'h1);
         i_pam_front.hw(3'h1 << i);
         settle;
         ichk({5'h09, i < 2});
         wr(pam_pkg::REG_CMD, 32'h4);
         wr(pam_pkg::REG_CMD, 32'h1);
         settle;
         rd(pam_pkg::REG_STAT, (32'h10 << i) | (32'h800 << i));
         i_pam_front.hw(3'h0);
         wr(pam_pkg::REG_CMD, 32'h4);
         settle;
         rd(pam_pkg::REG_STAT, i == 2 ? 32'h40 : 32'h0);
         wr(pam_pkg::REG_CMD, 32'h8);
         wr(pam_pkg::REG_CMD, 32'h1);
         settle;
         ichk(6'h20);
         wr(pam_pkg::REG_CMD, 32'h2);
      end
      $display("test hardware done");
   endtask
   // every event with the actions in turn, profiles, locked settings
   task automatic t_event;
      logic [15:0] s [3];
      logic [1:0]  a;
      logic        lo;
      logic [5:0]  ad;
      logic [5:0]  ei;
      logic [31:0] es;
      for (int e = 0; e < 5; e++) begin
         lo = e < 4 && e % 2 == 0;
         wr(pam_pkg::REG_EVTHR0 + 6'(4 * e), lo ? 32'h64 : 32'h3e8);
      end
      wr(pam_pkg::REG_PROF, 32'h1);
      rd(pam_pkg::REG_EVTHR0, 32'h0);
      wr(pam_pkg::REG_PROF, 32'h0);
      rd(pam_pkg::REG_EVTHR0, 32'h64);
      for (int e = 0; e < 5; e++) begin
         lo = e < 4 && e % 2 == 0;
         a = 2'(e % 3 + 1);
         ad = pam_pkg::REG_EVTHR0 + 6'(4 * e);
         wr(pam_pkg::REG_EVACT, 32'(a) << (2 * e));
         s = '{16'h01f4, 16'h01f4, 16'h01f4};
         s[e / 2] = lo ? 16'h0032 : 16'h07d0;
         i_pam_front.sample(s[0], s[1], s[2]);
         settle;
         ichk(6'h00);
         i_pam_front.sample(16'h01f4, 16'h01f4, 16'h01f4);
         wr(pam_pkg::REG_CMD, 32'h1);
         wr(ad, 32'h0);
         i_pam_front.sample(s[0], s[1], s[2]);
         settle;
         ei = {a != 3, a == 3, a >= 2, 1'b1, a == 3, 1'b0};
         ichk(ei);
         es = (32'h8000 << e) | (a == 3 ? 32'h80 : 32'h1);
         rd(pam_pkg::REG_STAT, es);
         wr(pam_pkg::REG_CMD, 32'h2);
         wr(pam_pkg::REG_CMD, 32'h4);
         settle;
         ichk(6'h00);
         rd(ad, lo ? 32'h64 : 32'h3e8);
      end
      $display("test event done");
   endtask

   // counts, verdict and end of run
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // main sequence
   initial begin
      mclk_i = 1'b0;
      srst_i = 1'b1;
      avs_address_i = 6'h00;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h0;
      n_mismatch = 0;
      cmp_count = 0;
      thr[0] = 20'(32'(UN) * pam_pkg::DEF_NUM / pam_pkg::DEF_DEN);
      thr[1] = 20'(32'(IN) * pam_pkg::DEF_NUM / pam_pkg::DEF_DEN);
      thr[2] = 20'(32'(PN) * pam_pkg::DEF_NUM / pam_pkg::DEF_DEN);
      repeat (8) @(posedge mclk_i);
      srst_i <= 1'b0;
      t_reset;
      t_alarm;
      t_hw;
      t_event;
      test_done;
   end
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge mclk_i);
      n_mismatch++;
      test_done;
   end
endmodule
